// ---- rtl/tff_framer.sv ----
`timescale 1ns/1ps
// Functional notes
// - Buffer holds 128 bytes, one frame.
// - Host writes and RAM copies both fill buffer.
// - Loading starts at byte zero; window needs ignore.
// - Fill count is readable in status.
// - Flush empties; flush while sending gives underflow.
// - Sending keeps contents for retransmission.
// - First write after sending flushes automatically.
// - Write when full: overflow, byte dropped.
// - Fetch from empty buffer: underflow, abort.
// - Error flags clear only on flush.
// - Ignore bit suppresses underflow, sends memory bytes.
// - Preamble length programmable, then fixed delimiter.
// - Length byte read first, sets byte count.
// - Auto checksum in own register, sent last.
// - Without auto checksum, check bytes come from buffer.
// - Delimiter and frame-done exceptions are raised.
// - Signal valid after eight symbols receiver on.
// - Live and strobe-latched clear-channel bits.
// - Clear channel updates four cycles after valid.
// - Preamble starts 192 us after start strobe.
// - Delimiter 0xa7; default preamble four zeros.
// - Checksum follows body, excludes length byte.
module tff_framer #(
	parameter int DEPTH = tff_pkg::BUF_BYTES,
	parameter int TURN_CYCLES = tff_pkg::TURNAROUND_CYCLES,
	parameter int VALID_CYCLES = tff_pkg::SIGNAL_VALID_CYCLES
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset,
	// Register bus.
	input wire tff_pkg::tff_apb_req_t apbReq,
	output tff_pkg::tff_apb_rsp_t apbRsp,
	// Copy path from the general RAM.
	input wire logic ramCopyValid,
	input wire logic [7:0] ramCopyData,
	// Receiver state and signal-level samples.
	input wire logic rxOn,
	input wire logic levelSample,
	input wire logic levelClear,
	// Modulator link.
	input wire logic linkClk,
	output logic txBit,
	output logic txActive,
	// Exceptions and channel status.
	output tff_pkg::tff_event_t events,
	output logic signalValid,
	output logic ccaLive,
	output logic ccaSampled
);
	import tff_pkg::*;

	localparam int CW = $clog2(DEPTH + 1);
	localparam int PW = $clog2(DEPTH);
	localparam int TW = $clog2(TURN_CYCLES + 1);
	localparam int VW = $clog2(VALID_CYCLES + 1);

	if (DEPTH < 4 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0 || TURN_CYCLES < 1
		|| VALID_CYCLES < 1) begin : g_bad_params
		$error("tff_framer: unsupported parameter values");
	end

	typedef enum logic [6:0] {
		S_IDLE = 7'b0000001,
		S_TURN = 7'b0000010,
		S_PRE = 7'b0000100,
		S_SFD = 7'b0001000,
		S_LEN = 7'b0010000,
		S_BODY = 7'b0100000,
		S_FCS = 7'b1000000
	} tff_state_t;

	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [CW-1:0] count;
		logic [PW-1:0] rdPtr;
		logic ovf;
		logic udf;
		logic rewrite;
		logic auto_checksum_bit;
		logic ignore;
		logic [3:0] preLen;
		tff_state_t state;
		logic [TW-1:0] turnTimer;
		logic [3:0] bitIdx;
		logic [7:0] shift;
		logic [6:0] bytesLeft;
		logic [15:0] crc;
		logic linkMeta;
		logic linkSync;
		logic linkPrev;
		logic [VW-1:0] validTimer;
		logic sigValid;
		logic [CCA_DELAY_CYCLES-1:0] validDly;
		logic ccaLive;
		logic ccaSampled;
		logic txBit;
		logic txActive;
		tff_event_t ev;
		tff_apb_rsp_t rsp;
	} tff_core_t;

	tff_core_t st;
	tff_core_t n;

	function automatic logic addrMapped(input logic [11:0] a);
		return (a == ADDR_CTRL) || (a == ADDR_CMD) || (a == ADDR_STATUS) || (a == ADDR_DATA)
			|| ((a >= ADDR_WIN_BASE) && (a < ADDR_WIN_BASE + 12'(DEPTH * 4))
			&& (a[1:0] == 2'b00));
	endfunction

	logic access, commit, mapped, wrCommit, winHit, hostWr, cmdWr, flushNow, startNow;
	logic linkEdge, byteEnd;
	logic [PW-1:0] winIdx;

	assign access = apbReq.psel & apbReq.penable;
	assign commit = access & st.rsp.pready;
	assign mapped = addrMapped(apbReq.paddr);
	assign wrCommit = commit & apbReq.pwrite & mapped;
	assign winHit = mapped && (apbReq.paddr >= ADDR_WIN_BASE);
	assign winIdx = apbReq.paddr[PW+1:2];
	assign hostWr = wrCommit && (apbReq.paddr == ADDR_DATA);
	assign cmdWr = wrCommit && (apbReq.paddr == ADDR_CMD);
	assign flushNow = cmdWr && apbReq.pwdata[CMD_FLUSH];
	assign startNow = cmdWr && (apbReq.pwdata[CMD_START]
		|| (apbReq.pwdata[CMD_START_CLEAR] && st.ccaLive));
	// The link clock is sampled through two flops before its rising edge is used.
	assign linkEdge = st.linkSync & ~st.linkPrev;
	assign byteEnd = (st.state == S_FCS) ? (st.bitIdx == 4'hf) : (st.bitIdx == 4'h7);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [1:0] srcValid;
		logic [1:0][7:0] srcData;
		logic [7:0] fetched;
		logic fetchBad;
		logic loadNext;
		logic tail;
		logic fb;
		logic [31:0] word;
		n = st;
		srcValid = {ramCopyValid, hostWr};
		srcData = {ramCopyData, apbReq.pwdata[7:0]};
		fetched = st.mem[st.rdPtr];
		fetchBad = (CW'(st.rdPtr) >= st.count) && !st.ignore;
		loadNext = 1'b0;
		tail = 1'b0;
		fb = st.shift[0] ^ st.crc[0];
		word = '0;
		n.linkMeta = linkClk;
		n.linkSync = st.linkMeta;
		n.linkPrev = st.linkSync;
		n.ev = '0;

		// Bus slave: one wait state, then the answer stands with pready.
		n.rsp.pready = access & ~st.rsp.pready;
		if (access & ~st.rsp.pready) begin
			n.rsp.pslverr = !mapped;
			if (apbReq.paddr == ADDR_CTRL) begin
				word[CTRL_AUTO_CHECKSUM_BIT] = st.auto_checksum_bit;
				word[CTRL_IGNORE] = st.ignore;
				word[CTRL_PRE_LSB +: 4] = st.preLen;
			end else if (apbReq.paddr == ADDR_STATUS) begin
				word[ST_COUNT_LSB +: 8] = 8'(st.count);
				word[ST_OVF] = st.ovf;
				word[ST_UDF] = st.udf;
				word[ST_ACTIVE] = st.txActive;
				word[ST_VALID] = st.sigValid;
				word[ST_CCA] = st.ccaLive;
				word[ST_CCA_SAMPLED] = st.ccaSampled;
			end else if (winHit) begin
				word[7:0] = st.mem[winIdx];
			end
			n.rsp.prdata = word;
		end

		// Framer; a flush in the same cycle takes over the whole transfer.
		unique case (st.state)
			S_IDLE: begin
			end
			S_TURN: begin
				n.turnTimer = st.turnTimer - 1'b1;
				if (st.turnTimer == '0) begin
					n.bitIdx = '0;
					n.bytesLeft = 7'(st.preLen);
					n.shift = (st.preLen == '0) ? SFD_VALUE : 8'h00;
					n.state = (st.preLen == '0) ? S_SFD : S_PRE;
				end
			end
			S_PRE, S_SFD, S_LEN, S_BODY, S_FCS: begin
				if (linkEdge && !flushNow) begin
					n.txBit = (st.state == S_FCS) ? st.crc[0] : st.shift[0];
					n.shift = {1'b0, st.shift[7:1]};
					n.bitIdx = st.bitIdx + 4'h1;
					if (st.state == S_BODY) begin
						n.crc = {1'b0, st.crc[15:1]} ^ (fb ? CRC_POLY_REV : 16'h0000);
					end
					if (st.state == S_FCS) begin
						n.crc = {1'b0, st.crc[15:1]};
					end
					if (byteEnd) begin
						n.bitIdx = '0;
						if (st.state == S_PRE) begin
							n.bytesLeft = st.bytesLeft - 7'd1;
							if (st.bytesLeft == 7'd1) begin
								n.state = S_SFD;
								n.shift = SFD_VALUE;
							end
						end else if (st.state == S_SFD) begin
							n.ev.sfd = 1'b1;
							n.state = S_LEN;
							loadNext = 1'b1;
							// Body count from the length byte, check bytes removed only with auto checksum on.
							if (!st.auto_checksum_bit) begin
								n.bytesLeft = fetched[6:0];
							end else begin
								n.bytesLeft = (fetched[6:0] < 7'd2) ? 7'd0 : fetched[6:0] - 7'd2;
							end
						end else if (st.state == S_LEN) begin
							tail = (st.bytesLeft == 7'd0);
							loadNext = !tail;
							n.state = S_BODY;
						end else if (st.state == S_BODY) begin
							n.bytesLeft = st.bytesLeft - 7'd1;
							tail = (st.bytesLeft == 7'd1);
							loadNext = !tail;
						end else begin
							n.state = S_IDLE;
							n.ev.frameDone = 1'b1;
							n.rewrite = 1'b1;
						end
						if (tail && st.auto_checksum_bit) begin
							n.state = S_FCS;
						end else if (tail) begin
							n.state = S_IDLE;
							n.ev.frameDone = 1'b1;
							n.rewrite = 1'b1;
						end
						if (loadNext && fetchBad) begin
							n.udf = 1'b1;
							n.ev.underflow = 1'b1;
							n.state = S_IDLE;
						end else if (loadNext) begin
							n.shift = fetched;
							n.rdPtr = st.rdPtr + 1'b1;
						end
					end
				end
			end
		endcase

		if (flushNow) begin
			n.count = '0;
			n.ovf = 1'b0;
			n.udf = 1'b0;
			n.rewrite = 1'b0;
			if (st.state != S_IDLE) begin
				n.udf = 1'b1;
				n.ev.underflow = 1'b1;
				n.state = S_IDLE;
			end
		end
		if (cmdWr && (apbReq.pwdata[CMD_SAMPLE] || apbReq.pwdata[CMD_START_CLEAR])) begin
			n.ccaSampled = st.ccaLive;
		end
		if (startNow) begin
			n.state = S_TURN;
			n.turnTimer = TW'(TURN_CYCLES - 1);
			n.crc = CRC_INIT;
			n.rdPtr = '0;
			n.bitIdx = '0;
		end
		if (wrCommit && (apbReq.paddr == ADDR_CTRL)) begin
			n.auto_checksum_bit = apbReq.pwdata[CTRL_AUTO_CHECKSUM_BIT];
			n.ignore = apbReq.pwdata[CTRL_IGNORE];
			n.preLen = apbReq.pwdata[CTRL_PRE_LSB +: 4];
		end
		if (wrCommit && winHit && st.ignore) begin
			n.mem[winIdx] = apbReq.pwdata[7:0];
		end

		// Host bytes first, then the RAM copy byte, both appended in order.
		for (int s = 0; s < 2; s++) begin
			if (srcValid[s] && !n.ovf) begin
				if (n.rewrite) begin
					n.count = '0;
					n.rewrite = 1'b0;
				end
				if (n.count == CW'(DEPTH)) begin
					n.ovf = 1'b1;
					n.ev.overflow = 1'b1;
				end else begin
					n.mem[n.count[PW-1:0]] = srcData[s];
					n.count = n.count + 1'b1;
				end
			end
		end

		// Signal level becomes valid after the receiver has been on long enough.
		if (!rxOn) begin
			n.validTimer = '0;
			n.sigValid = 1'b0;
			n.ccaLive = 1'b0;
		end else if (!st.sigValid) begin
			n.validTimer = st.validTimer + 1'b1;
			if (st.validTimer == VW'(VALID_CYCLES - 1)) begin
				n.sigValid = 1'b1;
			end
		end
		n.validDly = {st.validDly[CCA_DELAY_CYCLES-2:0], st.sigValid};
		if (rxOn && st.validDly[CCA_DELAY_CYCLES-2]
			&& (!st.validDly[CCA_DELAY_CYCLES-1] || levelSample)) begin
			n.ccaLive = levelClear;
		end
		n.txActive = n.state inside {S_PRE, S_SFD, S_LEN, S_BODY, S_FCS};
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st <= '0;
			st.state <= S_IDLE;
			st.auto_checksum_bit <= AUTO_CHECKSUM_BIT_RESET;
			st.preLen <= PREAMBLE_RESET;
		end else begin
			st <= n;
		end
	end

	assign apbRsp = st.rsp;
	assign txBit = st.txBit;
	assign txActive = st.txActive;
	assign events = st.ev;
	assign signalValid = st.sigValid;
	assign ccaLive = st.ccaLive;
	assign ccaSampled = st.ccaSampled;

	////////////////////////////////////////////////////////////////////////////////
	property p_overflow;
		@(posedge clk_sys) disable iff (reset)
		hostWr && !ramCopyValid && !flushNow && !st.ovf && !st.rewrite && (st.count == CW'(DEPTH))
			|=> st.ovf && events.overflow && (st.count == CW'(DEPTH));
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not raised");

	property p_flush;
		@(posedge clk_sys) disable iff (reset)
		flushNow && !hostWr && !ramCopyValid
			|=> (st.count == '0) && !st.ovf && (st.udf == ($past(st.state) != S_IDLE));
	endproperty
	a_flush: assert property (p_flush) else $error("flush result wrong");

	property p_persist;
		@(posedge clk_sys) disable iff (reset)
		(st.udf || st.ovf) && !flushNow
			|=> (st.udf || !$past(st.udf)) && (st.ovf || !$past(st.ovf));
	endproperty
	a_persist: assert property (p_persist) else $error("error flag lost");

	property p_sfd;
		@(posedge clk_sys) disable iff (reset)
		events.sfd |-> $past(st.state) == S_SFD && $past(st.bitIdx) == 4'h7 && $past(linkEdge);
	endproperty
	a_sfd: assert property (p_sfd) else $error("delimiter event misplaced");

	property p_start;
		@(posedge clk_sys) disable iff (reset)
		startNow |=> st.state == S_TURN && st.turnTimer == TW'(TURN_CYCLES - 1)
			&& st.crc == CRC_INIT && st.rdPtr == '0 && !txActive;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");

	property p_turn_end;
		@(posedge clk_sys) disable iff (reset)
		st.state == S_TURN && st.turnTimer == '0 && !cmdWr |=> txActive;
	endproperty
	a_turn_end: assert property (p_turn_end) else $error("preamble late");

	property p_cca;
		@(posedge clk_sys) disable iff (reset)
		$rose(st.sigValid) ##3 rxOn |=> st.ccaLive == $past(levelClear);
	endproperty
	a_cca: assert property (p_cca) else $error("clear channel not updated");

	property p_autoflush;
		@(posedge clk_sys) disable iff (reset)
		st.rewrite && hostWr && !ramCopyValid && !flushNow && !st.ovf
			|=> st.count == CW'(1) && st.mem[0] == $past(apbReq.pwdata[7:0]);
	endproperty
	a_autoflush: assert property (p_autoflush) else $error("no automatic flush");

	property p_ignore;
		@(posedge clk_sys) disable iff (reset)
		st.ignore && !flushNow |=> !events.underflow;
	endproperty
	a_ignore: assert property (p_ignore) else $error("underflow while ignored");

	property p_fcs;
		@(posedge clk_sys) disable iff (reset)
		st.state == S_FCS && linkEdge && !flushNow |=> txBit == $past(st.crc[0]);
	endproperty
	a_fcs: assert property (p_fcs) else $error("check bit wrong");

	property p_done;
		@(posedge clk_sys) disable iff (reset)
		events.frameDone |-> st.rewrite && !txActive && st.count == $past(st.count);
	endproperty
	a_done: assert property (p_done) else $error("frame done state wrong");

	c_done: cover property (@(posedge clk_sys) disable iff (reset) events.frameDone);
	c_overflow: cover property (@(posedge clk_sys) disable iff (reset) events.overflow);
	c_underflow: cover property (@(posedge clk_sys) disable iff (reset)
		events.underflow && !flushNow);
	c_sampled: cover property (@(posedge clk_sys) disable iff (reset) $rose(ccaSampled));
endmodule

// ---- rtl/tff_pkg.sv ----
package tff_pkg;
	// Clock and timing.
	localparam int CLK_PERIOD_NS = 25;
	localparam int TURNAROUND_NS = 192000;
	localparam int TURNAROUND_CYCLES = (TURNAROUND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYMBOL_NS = 16000;
	localparam int VALID_SYMBOLS = 8;
	localparam int SIGNAL_VALID_CYCLES =
		(VALID_SYMBOLS * SYMBOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CCA_DELAY_CYCLES = 4;

	// Frame format.
	localparam int BUF_BYTES = 128;
	localparam logic [7:0] SFD_VALUE = 8'ha7;
	localparam logic [15:0] CRC_POLY_REV = 16'h8408;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [3:0] PREAMBLE_RESET = 4'h4;

	// Register map.
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_CMD = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_DATA = 12'h010;
	localparam logic [11:0] ADDR_WIN_BASE = 12'h200;

	// Frame control fields.
	localparam int CTRL_AUTO_CHECKSUM_BIT = 0;
	localparam int CTRL_IGNORE = 1;
	localparam int CTRL_PRE_LSB = 4;
	localparam logic AUTO_CHECKSUM_BIT_RESET = 1'b1;

	// Command strobe bits.
	localparam int CMD_START = 0;
	localparam int CMD_START_CLEAR = 1;
	localparam int CMD_FLUSH = 2;
	localparam int CMD_SAMPLE = 3;

	// Status fields.
	localparam int ST_COUNT_LSB = 0;
	localparam int ST_OVF = 8;
	localparam int ST_UDF = 9;
	localparam int ST_ACTIVE = 10;
	localparam int ST_VALID = 11;
	localparam int ST_CCA = 12;
	localparam int ST_CCA_SAMPLED = 13;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} tff_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tff_apb_rsp_t;

	typedef struct packed {
		logic sfd;
		logic frameDone;
		logic overflow;
		logic underflow;
	} tff_event_t;
endpackage

// ---- tb/tff_link_model.sv ----
`timescale 1ns/1ps
module tff_link_model (
	// Control from the bench.
	input wire logic run,
	// Serial link.
	input wire logic txBit,
	output logic linkClk
);
	logic bits[$];

	////////////////////////////////////////////////////////////////////////////////
	// The bit clock only runs within frames and rests low between them.
	initial begin
		linkClk = 1'b0;
		#7;
		forever begin
			#100;
			linkClk = run ? ~linkClk : 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bits are taken midway through each slot, well after the framer has moved.
	always @(negedge linkClk) begin
		bits.push_back(txBit);
	end
endmodule

// ---- tb/tff_framer_tb.sv ----
`timescale 1ns/1ps
module tff_framer_tb;
	import tff_pkg::*;
	localparam int TURN = 20;
	localparam int VALID = 16;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	tff_apb_req_t req = '0;
	tff_apb_rsp_t rsp;
	logic ramCopyValid = 1'b0;
	logic [7:0] ramCopyData = 8'h00;
	logic rxOn = 1'b0;
	logic levelSample = 1'b0;
	logic levelClear = 1'b0;
	logic run = 1'b0;
	logic linkClk;
	logic txBit;
	logic txActive;
	logic signalValid;
	logic ccaLive;
	logic ccaSampled;
	tff_event_t events;
	int n_errors = 0;
	int cmp_count = 0;
	int nSfd = 0;
	int nDone = 0;
	int nOvf = 0;
	int nUdf = 0;
	int n;
	logic [31:0] rdata;
	logic slvErr;
	logic [7:0] frame[$];
	logic [15:0] crc;

	always #12.5 clk_sys = ~clk_sys;

	tff_framer #(.TURN_CYCLES(TURN), .VALID_CYCLES(VALID)) dut_u (
		.clk_sys(clk_sys), .reset(reset), .apbReq(req), .apbRsp(rsp),
		.ramCopyValid(ramCopyValid), .ramCopyData(ramCopyData), .rxOn(rxOn),
		.levelSample(levelSample), .levelClear(levelClear), .linkClk(linkClk),
		.txBit(txBit), .txActive(txActive), .events(events),
		.signalValid(signalValid), .ccaLive(ccaLive), .ccaSampled(ccaSampled)
	);
	tff_link_model link_u (.run(run), .txBit(txBit), .linkClk(linkClk));

	////////////////////////////////////////////////////////////////////////////////
	// One-cycle exception pulses are tallied here.
	always @(posedge clk_sys) begin
		nSfd += (events.sfd === 1'b1);
		nDone += (events.frameDone === 1'b1);
		nOvf += (events.overflow === 1'b1);
		nUdf += (events.underflow === 1'b1);
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic fail(input string msg);
		n_errors++;
		$display("mismatch at %0t: %s", $time, msg);
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) fail($sformatf("%s got %h expected %h", msg, got, exp));
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clk_sys);
		req.penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (rsp.pready !== 1'b1);
		rdata = rsp.prdata;
		slvErr = rsp.pslverr;
		req <= '0;
		@(posedge clk_sys);
	endtask

	task automatic st(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rdata & mask, exp, "register read");
	endtask

	task automatic cmd(input int b);
		apb(1'b1, ADDR_CMD, 32'h1 << b);
	endtask

	task automatic push(input logic [7:0] b);
		apb(1'b1, ADDR_DATA, {24'h0, b});
	endtask

	task automatic copyByte(input logic [7:0] b);
		ramCopyValid <= 1'b1;
		ramCopyData <= b;
		@(posedge clk_sys);
		ramCopyValid <= 1'b0;
		@(posedge clk_sys);
	endtask

	// Counts edges until the chosen output shows v; returns on the edge after.
	task automatic waitSig(input int w, input logic v, output int k);
		logic s;
		k = 1;
		#1;
		forever begin
			s = w == 0 ? txActive : w == 1 ? signalValid : ccaLive;
			if (s === v || k > 6000) break;
			@(posedge clk_sys);
			#1;
			k++;
		end
		@(posedge clk_sys);
	endtask

	function automatic logic [7:0] bitsByte(input int s);
		logic [7:0] b;
		for (int i = 0; i < 8; i++) b[i] = link_u.bits[s + i];
		return b;
	endfunction

	function automatic logic [15:0] crcOf(input int first, input int last);
		logic [15:0] c;
		c = CRC_INIT;
		for (int k = first; k <= last; k++) begin
			for (int i = 0; i < 8; i++) begin
				c = (c >> 1) ^ ((c[0] ^ frame[k][i]) ? CRC_POLY_REV : 16'h0000);
			end
		end
		return c;
	endfunction

	// Starts a frame, times the turnaround and checks the bytes seen on the link.
	task automatic send(input int pre);
		int s;
		link_u.bits.delete();
		run <= 1'b1;
		cmd(CMD_START);
		waitSig(0, 1'b1, n);
		cmp(n, TURN, "turnaround");
		waitSig(0, 1'b0, n);
		repeat (12) @(posedge clk_sys);
		run <= 1'b0;
		s = 0;
		while (s + 8 < link_u.bits.size() && bitsByte(s) !== SFD_VALUE) s++;
		cmp(bitsByte(s), SFD_VALUE, "delimiter");
		cmp((s + 4) / 8, pre, "preamble bytes");
		for (int k = 0; k < frame.size(); k++) begin
			cmp(bitsByte(s + 8 + 8 * k), frame[k], "byte");
		end
		@(posedge clk_sys);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#1000000;
		fail("watchdog expired");
		complete_run();
	end

	initial begin
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		st(ADDR_CTRL, 32'hffffffff, 32'h41);
		st(ADDR_STATUS, 32'hffffffff, 32'h0);
		apb(1'b0, 12'h0fc, 32'h0);
		cmp(slvErr, 1'b1, "unmapped address");
		// Auto checksum frame, sent twice, then a new frame begins.
		frame = '{8'h05, 8'h41, 8'h88, 8'h3c};
		for (int k = 0; k < 3; k++) push(frame[k]);
		copyByte(frame[3]);
		st(ADDR_STATUS, 32'hff, 32'h04);
		crc = crcOf(1, 3);
		frame.push_back(crc[7:0]);
		frame.push_back(crc[15:8]);
		send(4);
		send(4);
		st(ADDR_STATUS, 32'hff, 32'h04);
		cmp(nSfd, 2, "delimiter events");
		cmp(nDone, 2, "done events");
		push(8'h07);
		st(ADDR_STATUS, 32'hff, 32'h01);
		st(ADDR_WIN_BASE, 32'hff, 32'h07);
		// Fill to the brim through both paths, then one byte too many.
		cmd(CMD_FLUSH);
		for (int k = 0; k < BUF_BYTES; k++) begin
			if (k % 2) copyByte(8'(k)); else push(8'(k));
		end
		st(ADDR_STATUS, 32'h1ff, 32'h080);
		push(8'hee);
		st(ADDR_STATUS, 32'h1ff, 32'h180);
		st(ADDR_WIN_BASE + 12'h1fc, 32'hff, 32'h7f);
		cmp(nOvf, 1, "overflow event");
		cmd(CMD_FLUSH);
		st(ADDR_STATUS, 32'h3ff, 32'h0);
		// Length asks for more bytes than the buffer holds.
		frame = '{8'h0a, 8'h01};
		push(frame[0]);
		push(frame[1]);
		send(4);
		cmp(nUdf, 1, "underflow event");
		cmp(nDone, 2, "no done after abort");
		repeat (50) @(posedge clk_sys);
		st(ADDR_STATUS, 32'h200, 32'h200);
		cmd(CMD_FLUSH);
		st(ADDR_STATUS, 32'h3ff, 32'h0);
		cmd(CMD_START);
		cmd(CMD_FLUSH);
		st(ADDR_STATUS, 32'h6ff, 32'h200);
		cmp(nUdf, 2, "flush while busy");
		cmd(CMD_FLUSH);
		// Frame placed through the window with host-made check bytes.
		apb(1'b1, ADDR_CTRL, 32'h22);
		frame = '{8'h03, 8'h5a, 8'h12, 8'h34};
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, ADDR_WIN_BASE + 12'(4 * k), {24'h0, frame[k]});
		end
		st(ADDR_STATUS, 32'hff, 32'h0);
		send(2);
		cmp(nUdf, 2, "underflow suppressed");
		cmp(nDone, 3, "done event");
		apb(1'b1, ADDR_CTRL, 32'h20);
		apb(1'b1, ADDR_WIN_BASE + 12'h4, 32'hee);
		st(ADDR_WIN_BASE + 12'h4, 32'hff, 32'h5a);
		apb(1'b1, ADDR_CTRL, 32'h41);
		// Channel status after the receiver is switched on.
		levelClear <= 1'b1;
		rxOn <= 1'b1;
		waitSig(1, 1'b1, n);
		cmp(n >= VALID && n <= VALID + 2, 1'b1, "signal valid delay");
		waitSig(2, 1'b1, n);
		cmp(n, CCA_DELAY_CYCLES, "clear channel delay");
		st(ADDR_STATUS, 32'h3800, 32'h1800);
		cmd(CMD_SAMPLE);
		st(ADDR_STATUS, 32'h3800, 32'h3800);
		cmp(ccaSampled, 1'b1, "sampled flag");
		// A start on a clear channel is taken; with no link clock it is flushed away.
		cmd(CMD_START_CLEAR);
		waitSig(0, 1'b1, n);
		cmp(n, TURN, "clear start turnaround");
		cmd(CMD_FLUSH);
		cmd(CMD_FLUSH);
		levelClear <= 1'b0;
		levelSample <= 1'b1;
		@(posedge clk_sys);
		levelSample <= 1'b0;
		@(posedge clk_sys);
		st(ADDR_STATUS, 32'h3800, 32'h2800);
		cmd(CMD_START_CLEAR);
		repeat (TURN + 8) @(posedge clk_sys);
		cmp(txActive, 1'b0, "busy channel start");
		st(ADDR_STATUS, 32'h3c00, 32'h0800);
		rxOn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		st(ADDR_STATUS, 32'h1800, 32'h0);
		complete_run();
	end
endmodule
